// ---- acr_pkg.sv ----
// Constants shared by the configuration register block and its helpers.
// Assumes a single 50 MHz clock domain and a host-driven serial control port.
package acr_pkg;
    localparam logic [3:0] ACR_MAIN_CFG_ADDR = 4'h0;
    localparam int unsigned ACR_CFG_W = 16;
    localparam logic [15:0] ACR_CFG_RESET = 16'h2000;
    localparam int unsigned ACR_BIT_CAL = 15;
    localparam int unsigned ACR_BIT_PHASE = 14;
    localparam int unsigned ACR_BIT_PD_I = 11;
    localparam int unsigned ACR_BIT_PD_Q = 10;
    localparam int unsigned ACR_BIT_RSV9 = 9;
    localparam int unsigned ACR_BIT_LOW_RATE = 8;
    localparam int unsigned ACR_BIT_DES = 7;
    localparam int unsigned ACR_BIT_DE_Q = 6;
    localparam int unsigned ACR_BIT_DE_JOIN = 5;
    localparam int unsigned ACR_BIT_FMT = 4;
    localparam int unsigned ACR_BIT_STAMP = 3;
    localparam int unsigned ACR_BIT_SINGLE_RATE = 2;
    // Serial frame: read flag, three header bits, four address bits, sixteen data bits.
    localparam logic [4:0] ACR_FRAME_BITS = 5'h18;
    localparam logic [4:0] ACR_ADDR_FIRST = 5'h04;
    localparam logic [4:0] ACR_DATA_FIRST = 5'h08;
    typedef enum logic [2:0] {
        ACR_DES_OFF,
        ACR_DES_I,
        ACR_DES_Q,
        ACR_DES_IQ,
        ACR_DES_CLKIQ,
        ACR_DES_BAD
    } acr_des_mode_t;
endpackage

// ---- acr_cal_launch.sv ----
// Calibration launcher: one start pulse per rise of the combined request.
// Assumes a reset already synchronised to i_clk.
`timescale 1ns/1ns
`default_nettype none
module acr_cal_launch
    import acr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cal_bit,
    input wire logic i_cal_pin,
    output logic o_cal_start
);
    logic req;
    logic req_prev_r;
    logic req_prev_nxt;
    logic start_r;
    logic start_nxt;

    // A held request never relaunches; both sources must fall first.
    always_comb begin
        req = i_cal_bit | i_cal_pin;
        req_prev_nxt = req;
        start_nxt = req & ~req_prev_r;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            req_prev_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            req_prev_r <= req_prev_nxt;
            start_r <= start_nxt;
        end
    end

    assign o_cal_start = start_r;

    cal_rearm_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_cal_start |-> $past(!(i_cal_bit | i_cal_pin), 2))
        else $error("Calibration started without both sources low first.");
    cal_launch_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!req_prev_r && (i_cal_bit | i_cal_pin)) |=> o_cal_start)
        else $error("Calibration request did not launch.");
endmodule
`default_nettype wire

// ---- acr_des_decode.sv ----
// Dual-edge sampling mode decoder from the three mode bits and the clock-join flag.
// Assumes a reset already synchronised to i_clk.
`timescale 1ns/1ns
`default_nettype none
module acr_des_decode
    import acr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [2:0] i_mode_bits,
    input wire logic i_clock_joined,
    output acr_des_mode_t o_mode,
    output logic o_joined
);
    acr_des_mode_t mode_r;
    acr_des_mode_t mode_nxt;
    logic joined_r;
    logic joined_nxt;

    always_comb begin
        case ({i_mode_bits, i_clock_joined})
            4'h0: mode_nxt = ACR_DES_OFF;
            4'h8: mode_nxt = ACR_DES_I;
            4'hc: mode_nxt = ACR_DES_Q;
            4'ha: mode_nxt = ACR_DES_IQ;
            4'h1: mode_nxt = ACR_DES_CLKIQ;
            default: mode_nxt = ACR_DES_BAD;
        endcase
        // Inputs are joined only in the two joined modes; otherwise kept apart.
        joined_nxt = (mode_nxt == ACR_DES_IQ) || (mode_nxt == ACR_DES_CLKIQ);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_r <= ACR_DES_OFF;
            joined_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            joined_r <= joined_nxt;
        end
    end

    assign o_mode = mode_r;
    assign o_joined = joined_r;

    des_q_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode_bits == 3'h6 && !i_clock_joined) |=> (o_mode == ACR_DES_Q))
        else $error("Q input not selected in dual-edge mode.");
endmodule
`default_nettype wire

// ---- acr_main_config.sv ----
// Main configuration register with its serial control port and decoded controls.
// Assumes the host drives the serial pins synchronously to i_clk.
`timescale 1ns/1ns
`default_nettype none
module acr_main_config
    import acr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_extended_control_mode,
    input wire logic i_cal_pin,
    input wire logic i_i_channel_power_down_pin,
    input wire logic i_q_channel_power_down_pin,
    input wire logic i_clock_joined_mode,
    input wire logic i_scs_b,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_cal_start,
    output logic o_output_clock_phase_select,
    output logic o_ddr_phase_90,
    output logic o_i_channel_power_down,
    output logic o_q_channel_power_down,
    output logic o_low_rate_clock_select,
    output acr_des_mode_t o_des_mode,
    output logic o_des_mode_illegal,
    output logic o_dual_edge_joined_inputs,
    output logic o_twos_complement_select,
    output logic o_time_stamp_enable,
    output logic o_single_rate_output_select
);
    logic rst_meta_r;
    logic rst_b_s;

    // Reset asserts at once and releases after two clean edges.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_b_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_b_s <= rst_meta_r;
        end
    end

    // Serial port and stored register.
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [3:0] addr_r;
    logic [3:0] addr_nxt;
    logic rw_r;
    logic rw_nxt;
    logic sclk_prev_r;
    logic sdo_r;
    logic sdo_nxt;
    logic sdo_oe_r;
    logic sdo_oe_nxt;
    logic sclk_rise;
    logic wr_commit;

    always_comb begin
        cfg_nxt = cfg_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        rdata_nxt = rdata_r;
        addr_nxt = addr_r;
        rw_nxt = rw_r;
        sdo_nxt = sdo_r;
        sdo_oe_nxt = sdo_oe_r;
        wr_commit = 1'b0;
        sclk_rise = i_sclk & ~sclk_prev_r;
        if (i_scs_b) begin
            // Deselect ends any frame; a partial write is dropped.
            bit_cnt_nxt = 5'h00;
            sdo_oe_nxt = 1'b0;
            sdo_nxt = 1'b0;
        end else if (sclk_rise && bit_cnt_r < ACR_FRAME_BITS) begin
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            shift_nxt = {shift_r[14:0], i_sdi};
            if (bit_cnt_r == 5'h00) begin
                rw_nxt = i_sdi;
            end
            if (bit_cnt_r >= ACR_ADDR_FIRST && bit_cnt_r < ACR_DATA_FIRST) begin
                addr_nxt = {addr_r[2:0], i_sdi};
            end
            if (bit_cnt_r == ACR_DATA_FIRST - 5'h01) begin
                // Unmapped addresses read as zero.
                rdata_nxt = ({addr_r[2:0], i_sdi} == ACR_MAIN_CFG_ADDR) ? cfg_r : 16'h0000;
                sdo_nxt = rw_r & rdata_nxt[15];
                sdo_oe_nxt = rw_r;
            end else if (bit_cnt_r >= ACR_DATA_FIRST) begin
                rdata_nxt = {rdata_r[14:0], 1'b0};
                sdo_nxt = rw_r & rdata_r[14];
                if (bit_cnt_r == ACR_FRAME_BITS - 5'h01) begin
                    sdo_oe_nxt = 1'b0;
                end
            end
            if (bit_cnt_r == ACR_FRAME_BITS - 5'h01 && !rw_r && addr_r == ACR_MAIN_CFG_ADDR) begin
                // The calibration bit is stored as written and never self-clears.
                cfg_nxt = {shift_r[14:0], i_sdi};
                wr_commit = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            cfg_r <= ACR_CFG_RESET;
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
            rdata_r <= 16'h0000;
            addr_r <= 4'h0;
            rw_r <= 1'b0;
            sclk_prev_r <= 1'b0;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            rdata_r <= rdata_nxt;
            addr_r <= addr_nxt;
            rw_r <= rw_nxt;
            sclk_prev_r <= i_sclk;
            sdo_r <= sdo_nxt;
            sdo_oe_r <= sdo_oe_nxt;
        end
    end

    assign o_sdo = sdo_r;
    assign o_sdo_oe = sdo_oe_r;

    // Decoded controls, all registered.
    logic [15:0] eff;
    logic phase_sel_r;
    logic phase_sel_nxt;
    logic phase_90_r;
    logic phase_90_nxt;
    logic pd_i_r;
    logic pd_i_nxt;
    logic pd_q_r;
    logic pd_q_nxt;
    logic low_rate_r;
    logic low_rate_nxt;
    logic twos_r;
    logic twos_nxt;
    logic stamp_r;
    logic stamp_nxt;
    logic single_r;
    logic single_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic clk_join;
    acr_des_mode_t des_mode;
    logic des_joined;

    always_comb begin
        // Outside extended control the register is bypassed by its reset value.
        eff = i_extended_control_mode ? cfg_r : ACR_CFG_RESET;
        clk_join = i_extended_control_mode & i_clock_joined_mode;
        phase_sel_nxt = eff[ACR_BIT_PHASE];
        phase_90_nxt = ~eff[ACR_BIT_SINGLE_RATE] & eff[ACR_BIT_PHASE];
        // Power-down pins act in every mode; only the register bits are gated.
        pd_i_nxt = eff[ACR_BIT_PD_I] | i_i_channel_power_down_pin;
        pd_q_nxt = eff[ACR_BIT_PD_Q] | i_q_channel_power_down_pin;
        low_rate_nxt = eff[ACR_BIT_LOW_RATE];
        twos_nxt = eff[ACR_BIT_FMT];
        stamp_nxt = eff[ACR_BIT_STAMP];
        single_nxt = eff[ACR_BIT_SINGLE_RATE];
        illegal_nxt = (des_mode == ACR_DES_BAD);
    end

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            phase_sel_r <= 1'b0;
            phase_90_r <= 1'b0;
            pd_i_r <= 1'b0;
            pd_q_r <= 1'b0;
            low_rate_r <= 1'b0;
            twos_r <= 1'b0;
            stamp_r <= 1'b0;
            single_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            phase_sel_r <= phase_sel_nxt;
            phase_90_r <= phase_90_nxt;
            pd_i_r <= pd_i_nxt;
            pd_q_r <= pd_q_nxt;
            low_rate_r <= low_rate_nxt;
            twos_r <= twos_nxt;
            stamp_r <= stamp_nxt;
            single_r <= single_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    acr_cal_launch u_cal (
        .i_clk(i_clk),
        .i_rst_b(rst_b_s),
        .i_cal_bit(eff[ACR_BIT_CAL]),
        .i_cal_pin(i_cal_pin),
        .o_cal_start(o_cal_start)
    );

    acr_des_decode u_des (
        .i_clk(i_clk),
        .i_rst_b(rst_b_s),
        .i_mode_bits(eff[ACR_BIT_DES:ACR_BIT_DE_JOIN]),
        .i_clock_joined(clk_join),
        .o_mode(des_mode),
        .o_joined(des_joined)
    );

    assign o_output_clock_phase_select = phase_sel_r;
    assign o_ddr_phase_90 = phase_90_r;
    assign o_i_channel_power_down = pd_i_r;
    assign o_q_channel_power_down = pd_q_r;
    assign o_low_rate_clock_select = low_rate_r;
    assign o_des_mode = des_mode;
    assign o_des_mode_illegal = illegal_r;
    assign o_dual_edge_joined_inputs = des_joined;
    assign o_twos_complement_select = twos_r;
    assign o_time_stamp_enable = stamp_r;
    assign o_single_rate_output_select = single_r;

    cal_bit_hold_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        ($past(cfg_r[ACR_BIT_CAL]) && !$past(wr_commit)) |-> cfg_r[ACR_BIT_CAL])
        else $error("Calibration bit cleared without a host write.");
    ddr_phase_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (i_extended_control_mode && !cfg_r[ACR_BIT_SINGLE_RATE]) |=>
        (o_ddr_phase_90 == $past(cfg_r[ACR_BIT_PHASE])))
        else $error("DDR phase does not follow the phase bit.");
    phase_sel_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        i_extended_control_mode |=>
        (o_output_clock_phase_select == $past(cfg_r[ACR_BIT_PHASE])))
        else $error("Phase select does not follow its bit.");
    i_power_down_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (i_extended_control_mode && cfg_r[ACR_BIT_PD_I]) |=> o_i_channel_power_down)
        else $error("I channel not powered down.");
    i_power_pin_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        i_i_channel_power_down_pin |=> o_i_channel_power_down)
        else $error("I power-down pin ignored.");
    q_power_bit_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (i_extended_control_mode && !cfg_r[ACR_BIT_PD_Q] && !i_q_channel_power_down_pin)
        |=> !o_q_channel_power_down)
        else $error("Q channel powered down with bit and pin low.");
    q_power_pin_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        i_q_channel_power_down_pin |=> o_q_channel_power_down)
        else $error("Q power-down pin ignored.");
    des_enable_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (i_extended_control_mode && cfg_r[7:5] == 3'h4 && !i_clock_joined_mode)
        |=> (o_des_mode == ACR_DES_I))
        else $error("Dual-edge I mode not entered.");
    des_illegal_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (o_des_mode == ACR_DES_BAD) |=> o_des_mode_illegal)
        else $error("Illegal dual-edge setting not flagged.");
    joined_sep_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (!cfg_r[ACR_BIT_DE_JOIN] && !i_clock_joined_mode) |=> !o_dual_edge_joined_inputs)
        else $error("Inputs joined with joined bit clear.");
    format_sel_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        i_extended_control_mode |=> (o_twos_complement_select == $past(cfg_r[ACR_BIT_FMT])))
        else $error("Output format does not follow its bit.");
    stamp_en_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        i_extended_control_mode |=> (o_time_stamp_enable == $past(cfg_r[ACR_BIT_STAMP])))
        else $error("Time stamp enable does not follow its bit.");
    rate_sel_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (i_extended_control_mode && cfg_r[ACR_BIT_SINGLE_RATE]) |=> o_single_rate_output_select)
        else $error("Single data rate not selected.");
    non_ext_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (!i_extended_control_mode)[*2] |-> (!o_twos_complement_select &&
        !o_time_stamp_enable && !o_single_rate_output_select &&
        (!o_cal_start || $past(i_cal_pin))))
        else $error("Register setting took effect outside extended control.");
    low_rate_a: assert property (@(posedge i_clk) disable iff (!rst_b_s)
        (!i_extended_control_mode) |=> !o_low_rate_clock_select)
        else $error("Low-rate select took effect outside extended control.");
endmodule
`default_nettype wire

// ---- acr_host_model.sv ----
// Host controller model that frames register writes and reads on the serial control port.
// Assumes i_clk is the block clock; the serial clock stays low outside frames.
`timescale 1ns/1ns
`default_nettype none
module acr_host_model
    import acr_pkg::*;
#(
    parameter bit SLOW_SAMPLE_CLK = 1'b1
)
(
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_scs_b,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_scs_b = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask

    // Each serial phase lasts two block clocks so every rise is seen exactly once.
    task automatic frame(input logic rd, input logic [3:0] a, input logic [15:0] wd,
                         output logic [15:0] rdata, output logic oe_ok);
        logic [23:0] bits;
        bits = {rd, 3'h0, a, wd};
        rdata = 16'h0000;
        oe_ok = 1'b1;
        tick();
        o_scs_b = 1'b0;
        for (int n = 0; n < 24; n++) begin
            o_sdi = bits[23-n];
            tick();
            tick();
            if (n >= 8) begin
                rdata[23-n] = i_sdo;
                oe_ok = oe_ok & i_sdo_oe;
            end
            o_sclk = 1'b1;
            tick();
            tick();
            o_sclk = 1'b0;
        end
        o_scs_b = 1'b1;
        // A released data line must not keep showing the last bit.
        o_sdi = ~o_sdi;
        tick();
    endtask

    task automatic write(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic k;
        if (a == ACR_MAIN_CFG_ADDR) begin
            d[9] = 1'b0;
            d[1:0] = 2'b00;
            // The bench clock is far below the low-rate threshold.
            if (SLOW_SAMPLE_CLK) begin
                d[8] = 1'b1;
            end
        end
        frame(1'b0, a, d, r, k);
    endtask

    task automatic read(input logic [3:0] a, output logic [15:0] d, output logic ok);
        frame(1'b1, a, 16'h0000, d, ok);
    endtask
endmodule
`default_nettype wire

// ---- tb_acr_main_config.sv ----
// Self-checking bench for the main configuration register block.
// Assumes the host model drives the serial port; pins are driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_acr_main_config
    import acr_pkg::*;
;
    logic clk, rst_b, ext_mode, cal_pin, pd_i_pin, pd_q_pin, clk_join;
    logic scs_b, sclk, sdi, sdo, sdo_oe, cal_start, phase, ddr90, pd_i, pd_q, low_rate;
    logic des_bad, joined, fmt, stamp, single_rate, oe_ok;
    logic [15:0] rd;
    acr_des_mode_t des_mode;
    int fails = 0;
    int checked = 0;
    int cal_count = 0;
    logic [2:0] mb [6] = '{3'b000, 3'b100, 3'b110, 3'b101, 3'b000, 3'b010};
    logic cj [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic ej [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    acr_des_mode_t em [6] = '{ACR_DES_OFF, ACR_DES_I, ACR_DES_Q, ACR_DES_IQ, ACR_DES_CLKIQ,
                              ACR_DES_BAD};

    acr_main_config dut (.i_clk(clk), .i_rst_b(rst_b), .i_extended_control_mode(ext_mode),
        .i_cal_pin(cal_pin), .i_i_channel_power_down_pin(pd_i_pin),
        .i_q_channel_power_down_pin(pd_q_pin), .i_clock_joined_mode(clk_join),
        .i_scs_b(scs_b), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .o_cal_start(cal_start), .o_output_clock_phase_select(phase),
        .o_ddr_phase_90(ddr90), .o_i_channel_power_down(pd_i), .o_q_channel_power_down(pd_q),
        .o_low_rate_clock_select(low_rate), .o_des_mode(des_mode),
        .o_des_mode_illegal(des_bad), .o_dual_edge_joined_inputs(joined),
        .o_twos_complement_select(fmt), .o_time_stamp_enable(stamp),
        .o_single_rate_output_select(single_rate));

    acr_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_scs_b(scs_b),
        .o_sclk(sclk), .o_sdi(sdi));

    initial begin
        clk = 1'b0;
    end
    always #10 clk = ~clk;

    always @(posedge clk) begin
        if (cal_start === 1'b1) begin
            cal_count <= cal_count + 1;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] d);
        host.write(ACR_MAIN_CFG_ADDR, d);
        step(4);
    endtask

    task automatic chk_out(input logic [7:0] e);
        `CHK({phase, ddr90, pd_i, pd_q, low_rate, fmt, stamp, single_rate}, e)
    endtask

    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset;
        chk_out(8'h00);
        `CHK(des_mode, ACR_DES_OFF)
        ext_mode = 1'b1;
        step(3);
        host.read(ACR_MAIN_CFG_ADDR, rd, oe_ok);
        `CHK(rd, ACR_CFG_RESET)
        `CHK(oe_ok, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_fields;
        ext_mode = 1'b0;
        wr(16'h4c1c);
        chk_out(8'h00);
        ext_mode = 1'b1;
        step(3);
        chk_out(8'hbf);
        host.read(ACR_MAIN_CFG_ADDR, rd, oe_ok);
        `CHK(rd, 16'h4d1c)
        wr(16'h4000);
        chk_out(8'hc8);
        wr(16'h0000);
        chk_out(8'h08);
        `CHK(joined, 1'b0)
        $display("test fields done");
    endtask

    task automatic t_pins;
        pd_q_pin = 1'b1;
        step(3);
        chk_out(8'h18);
        pd_i_pin = 1'b1;
        step(3);
        chk_out(8'h38);
        ext_mode = 1'b0;
        step(3);
        chk_out(8'h30);
        pd_i_pin = 1'b0;
        pd_q_pin = 1'b0;
        ext_mode = 1'b1;
        step(3);
        chk_out(8'h08);
        $display("test pins done");
    endtask

    task automatic t_des;
        for (int i = 0; i < 6; i++) begin
            clk_join = cj[i];
            wr({8'h01, mb[i], 5'h00});
            `CHK(des_mode, em[i])
            `CHK(joined, ej[i])
            `CHK(des_bad, em[i] == ACR_DES_BAD)
        end
        clk_join = 1'b0;
        wr(16'h0000);
        $display("test dual edge done");
    endtask

    task automatic t_cal;
        int c;
        c = cal_count;
        wr(16'h8000);
        `CHK(cal_count - c, 1)
        wr(16'h8000);
        `CHK(cal_count - c, 1)
        host.read(ACR_MAIN_CFG_ADDR, rd, oe_ok);
        `CHK(rd, 16'h8100)
        wr(16'h0000);
        wr(16'h8000);
        `CHK(cal_count - c, 2)
        cal_pin = 1'b1;
        step(5);
        wr(16'h0000);
        `CHK(cal_count - c, 2)
        cal_pin = 1'b0;
        step(5);
        cal_pin = 1'b1;
        step(5);
        `CHK(cal_count - c, 3)
        cal_pin = 1'b0;
        step(3);
        $display("test calibration done");
    endtask

    task automatic t_bad_addr;
        host.write(4'h1, 16'hffff);
        step(4);
        chk_out(8'h08);
        host.read(ACR_MAIN_CFG_ADDR, rd, oe_ok);
        `CHK(rd, 16'h0100)
        host.read(4'h1, rd, oe_ok);
        `CHK(rd, 16'h0000)
        $display("test unmapped done");
    endtask

    initial begin
        rst_b = 1'b0;
        ext_mode = 1'b0;
        cal_pin = 1'b0;
        pd_i_pin = 1'b0;
        pd_q_pin = 1'b0;
        clk_join = 1'b0;
        step(3);
        rst_b = 1'b1;
        step(5);
        t_reset();
        t_fields();
        t_pins();
        t_des();
        t_cal();
        t_bad_addr();
        test_done();
    end

    // Whole run is about 2200 cycles; this allows about nine times that.
    initial begin
        #400000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
